// *** hw/albs_params.svh ***
// Purpose: Constants for the adapter link bring-up sequencer.
// Assumes: 250 MHz core clock, 4 ns period.
// Notes: Timeout figures are in microseconds and default to plain values.
`ifndef ALBS_PARAMS_SVH
`define ALBS_PARAMS_SVH
`define ALBS_CLK_MHZ 250
`define ALBS_CONFIRM_TIMEOUT_US 1000
`define ALBS_DISPOSAL_PERIOD_US 1000
`define ALBS_INIT_REPLY_TIMEOUT_US 1000
`define ALBS_GENERAL_REPLY_TIMEOUT_US 1000
`define ALBS_RES_NORMAL 2'h0
`define ALBS_RES_TYPE_MISMATCH 2'h1
`define ALBS_RES_OBJ_MISMATCH 2'h2
`define ALBS_RES_DISPOSAL 2'h3
`endif

// *** hw/albs_pkg.sv ***
// Purpose: Types shared by the adapter link bring-up sequencer.
// Assumes: Nothing beyond the params header.
// Notes: The state enum is Gray-coded along the usual path.
package albs_pkg;
	typedef enum logic [3:0] {
		ALBS_POWERUP = 4'h0,
		ALBS_CONF_WAIT = 4'h1,
		ALBS_STANDBY = 4'h3,
		ALBS_INIT_REPLY = 4'h2,
		ALBS_INIT_RUN = 4'h6,
		ALBS_DONE_WAIT = 4'h7,
		ALBS_READY = 4'h5,
		ALBS_UNRECOG = 4'h4,
		ALBS_DISPOSE = 4'hC
	} albs_state_e;
	typedef struct packed {
		logic send_confirm;
		logic send_init_reply;
		logic send_done_note;
		logic clear_obj;
		logic clear_if;
		logic start_init;
	} albs_cmd_s;
	typedef struct packed {
		albs_state_e state;
		logic [31:0] timer;
		logic retried;
		albs_cmd_s cmd;
		logic standby;
		logic unrecognized;
		logic ready;
	} albs_reg_s;
endpackage

// *** hw/albs_sequencer.sv ***
// Purpose: Adapter-side bring-up sequencer for confirmation and initialization.
// Assumes: Frame layer decodes replies into one-cycle pulses on core_clk.
// Notes: Frame errors never reach this block; the framer drops them.
// Summary of operation
// [R1] Equipment rejects all frames except confirmation frames while confirming.
// [R2] Equipment checks type and objects, replies within confirm reply timeout.
// [R3] Equipment reports mismatch as an error code in the result field.
// [R4] On type mismatch equipment waits reset delay, resets adapter, awaits request.
// [R5] Three type mismatches give disposal result, then discard, reset, unrecognized.
// [R6] Equipment ignores frame errors; no request in disposal period resets again.
// [R7] Three missing requests make equipment discard data, reset, go unrecognized.
// [R8] After power-on adapter sends confirmation request; object count zero if none.
// [R9] Normal or type mismatch gives standby; object mismatch discards objects first; the code pulses clear_obj in the same cycle that standby rises.
// [R10] Disposal result discards all data, unrecognized within the disposal period.
// [R11] Ignore frame errors; resend once on timeout, then discard and go unrecognized.
// [R12] Equipment sends initialization request after entering object construction.
// [R13] Equipment resends initialization once, then goes stand-alone.
// [R14] Equipment waits completion wait period, else stand-alone operation.
// [R15] Equipment acknowledges completion within the general reply timeout.
// [R16] Keep-data initialization request: reply in time, then start lower-layer startup; the code raises start_init in the same cycle as send_init_reply.
// [R17] Discard-data initialization request: clear objects before replying.
// [R18] When internal initialization ends, send completion notification.
// [R19] Resend completion once without acceptance, then wait for a new request.
// [R20] All timeout periods are configurable cycle counts.
`timescale 1ns/1ps
`include "albs_params.svh"
module albs_sequencer
	import albs_pkg::*;
#(
	parameter int unsigned CONFIRM_CYC = `ALBS_CONFIRM_TIMEOUT_US * `ALBS_CLK_MHZ, // see [R20]
	parameter int unsigned DISPOSAL_CYC = `ALBS_DISPOSAL_PERIOD_US * `ALBS_CLK_MHZ,
	parameter int unsigned GENERAL_CYC = `ALBS_GENERAL_REPLY_TIMEOUT_US * `ALBS_CLK_MHZ
)
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic confirm_rsp,
	input wire logic [1:0] confirm_result,
	input wire logic init_req,
	input wire logic init_discard,
	input wire logic init_finished,
	input wire logic done_ack,
	output albs_cmd_s cmd,
	output logic standby,
	output logic unrecognized,
	output logic ready
);

	////////////////////////////////////////////////////////////////////////////
	albs_reg_s r;
	albs_reg_s next_r;

	// The timer only runs down; a zero count marks the period as spent.
	function automatic logic expired(input logic [31:0] t);
		expired = (t == 32'h0000_0000);
	endfunction

	always_comb
	begin
		next_r = r;
		next_r.cmd = '0;
		if (!expired(r.timer))
			next_r.timer = r.timer - 32'h0000_0001;
		case (r.state)
			ALBS_POWERUP:
			begin
				next_r.cmd.send_confirm = 1'b1; // see [R8]
				next_r.timer = CONFIRM_CYC;
				next_r.retried = 1'b0;
				next_r.state = ALBS_CONF_WAIT;
			end
			ALBS_CONF_WAIT:
			begin
				if (confirm_rsp)
				begin
					case (confirm_result)
						`ALBS_RES_OBJ_MISMATCH:
						begin
							next_r.cmd.clear_obj = 1'b1; // see [R9]
							next_r.state = ALBS_STANDBY;
						end
						`ALBS_RES_DISPOSAL:
						begin
							next_r.cmd.clear_obj = 1'b1; // see [R10]
							next_r.cmd.clear_if = 1'b1;
							next_r.state = ALBS_UNRECOG;
						end
						default:
							next_r.state = ALBS_STANDBY; // see [R9]
					endcase
				end
				else if (expired(r.timer))
				begin
					if (!r.retried)
					begin
						next_r.cmd.send_confirm = 1'b1; // see [R11]
						next_r.retried = 1'b1;
						next_r.timer = CONFIRM_CYC;
					end
					else
					begin
						next_r.cmd.clear_obj = 1'b1; // see [R11]
						next_r.cmd.clear_if = 1'b1;
						next_r.state = ALBS_UNRECOG;
					end
				end
			end
			ALBS_STANDBY, ALBS_READY:
			begin
				if (init_req)
				begin
					next_r.cmd.clear_obj = init_discard; // see [R17]
					next_r.state = ALBS_INIT_REPLY;
				end
			end
			ALBS_INIT_REPLY:
			begin
				next_r.cmd.send_init_reply = 1'b1; // see [R16]
				next_r.cmd.start_init = 1'b1;
				next_r.state = ALBS_INIT_RUN;
			end
			ALBS_INIT_RUN:
			begin
				if (init_finished)
				begin
					next_r.cmd.send_done_note = 1'b1; // see [R18]
					next_r.timer = GENERAL_CYC;
					next_r.retried = 1'b0;
					next_r.state = ALBS_DONE_WAIT;
				end
			end
			ALBS_DONE_WAIT:
			begin
				if (done_ack)
					next_r.state = ALBS_READY;
				else if (expired(r.timer))
				begin
					if (!r.retried)
					begin
						next_r.cmd.send_done_note = 1'b1; // see [R19]
						next_r.retried = 1'b1;
						next_r.timer = GENERAL_CYC;
					end
					else
						next_r.state = ALBS_STANDBY; // see [R19]
				end
			end
			ALBS_UNRECOG:
				next_r.state = ALBS_UNRECOG;
			default:
				next_r.state = ALBS_POWERUP;
		endcase
		next_r.standby = (next_r.state == ALBS_STANDBY);
		next_r.unrecognized = (next_r.state == ALBS_UNRECOG);
		next_r.ready = (next_r.state == ALBS_READY);
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			r <= '{state: ALBS_POWERUP, timer: 32'h0000_0000, retried: 1'b0,
				cmd: '0, standby: 1'b0, unrecognized: 1'b0, ready: 1'b0};
		else
			r <= next_r;
	end

	assign cmd = r.cmd;
	assign standby = r.standby;
	assign unrecognized = r.unrecognized;
	assign ready = r.ready;

	////////////////////////////////////////////////////////////////////////////
	// Checks sit beside the logic; none of them bounds the disposal period.
	property p_confirm_after_reset;
		@(posedge core_clk) $fell(sys_rst) |-> ##1 cmd.send_confirm;
	endproperty
	a_confirm_after_reset: assert property (p_confirm_after_reset) // see [R8]
		else $error("Confirmation request not sent after reset.");

	property p_obj_mismatch;
		@(posedge core_clk) disable iff (sys_rst)
		r.state == ALBS_CONF_WAIT && confirm_rsp && confirm_result == `ALBS_RES_OBJ_MISMATCH
		|=> cmd.clear_obj && standby;
	endproperty
	a_obj_mismatch: assert property (p_obj_mismatch) // see [R9]
		else $error("Object mismatch did not discard and enter standby.");

	property p_normal_standby;
		@(posedge core_clk) disable iff (sys_rst)
		r.state == ALBS_CONF_WAIT && confirm_rsp && confirm_result == `ALBS_RES_NORMAL
		|=> standby && !cmd.clear_obj;
	endproperty
	a_normal_standby: assert property (p_normal_standby) // see [R9]
		else $error("Normal result did not enter standby cleanly.");

	property p_disposal;
		@(posedge core_clk) disable iff (sys_rst)
		r.state == ALBS_CONF_WAIT && confirm_rsp && confirm_result == `ALBS_RES_DISPOSAL
		|=> unrecognized && cmd.clear_if && cmd.clear_obj;
	endproperty
	a_disposal: assert property (p_disposal) // see [R10]
		else $error("Disposal result did not discard and go unrecognized.");

	property p_confirm_retry;
		@(posedge core_clk) disable iff (sys_rst)
		r.state == ALBS_CONF_WAIT && !confirm_rsp && expired(r.timer) && !r.retried
		|=> cmd.send_confirm && r.state == ALBS_CONF_WAIT;
	endproperty
	a_confirm_retry: assert property (p_confirm_retry) // see [R11]
		else $error("Confirmation request not resent on timeout.");

	property p_confirm_giveup;
		@(posedge core_clk) disable iff (sys_rst)
		r.state == ALBS_CONF_WAIT && !confirm_rsp && expired(r.timer) && r.retried
		|=> unrecognized && cmd.clear_if;
	endproperty
	a_confirm_giveup: assert property (p_confirm_giveup) // see [R11]
		else $error("Second confirmation timeout did not go unrecognized.");

	property p_init_reply;
		@(posedge core_clk) disable iff (sys_rst)
		standby && init_req |=> cmd.clear_obj == $past(init_discard)
		##1 cmd.send_init_reply && cmd.start_init;
	endproperty
	a_init_reply: assert property (p_init_reply) // see [R16] [R17]
		else $error("Initialization request not answered in order.");

	property p_done_note;
		@(posedge core_clk) disable iff (sys_rst)
		r.state == ALBS_INIT_RUN && init_finished |=> cmd.send_done_note;
	endproperty
	a_done_note: assert property (p_done_note) // see [R18]
		else $error("Completion notification missing.");

	property p_done_giveup;
		@(posedge core_clk) disable iff (sys_rst)
		r.state == ALBS_DONE_WAIT && !done_ack && expired(r.timer) && r.retried
		|=> standby && !cmd.send_done_note;
	endproperty
	a_done_giveup: assert property (p_done_giveup) // see [R19]
		else $error("Unanswered resend did not return to waiting.");

	c_ready: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(ready));
	c_unrec: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(unrecognized));
	c_resend: cover property (@(posedge core_clk) disable iff (sys_rst)
		cmd.send_done_note && r.retried);
endmodule

// *** dv/albs_host_model.sv ***
// Purpose: Host equipment model that answers the adapter's bring-up frames.
// Assumes: Answers are one-cycle pulses launched 1 ns after a clock edge.
// Notes: The result lines change every cycle while no answer is valid.
`timescale 1ns/1ps
module albs_host_model
	import albs_pkg::*;
(
	input wire logic core_clk,
	input albs_cmd_s cmd,
	input wire logic rsp_en,
	input wire logic [1:0] result,
	input wire logic ack_en,
	input wire logic [7:0] dly,
	output logic confirm_rsp,
	output logic [1:0] confirm_result,
	output logic done_ack
);
	logic [1:0] res_q = 2'h0;
	logic [1:0] pat = 2'h0;
	initial
	begin
		confirm_rsp = 1'b0;
		done_ack = 1'b0;
	end
	assign confirm_result = confirm_rsp ? res_q : pat;
	always @(posedge core_clk)
		pat <= pat + 2'h1;
	// Only confirmation requests get a confirmation answer; dly sets the promptness.
	always @(posedge core_clk)
	begin
		if (cmd.send_confirm === 1'b1 && rsp_en)
		begin
			repeat (dly) @(posedge core_clk);
			#1 res_q = result;
			confirm_rsp = 1'b1;
			@(posedge core_clk);
			#1 confirm_rsp = 1'b0;
		end
	end
	always @(posedge core_clk)
	begin
		if (cmd.send_done_note === 1'b1 && ack_en)
		begin
			repeat (dly) @(posedge core_clk);
			#1 done_ack = 1'b1;
			@(posedge core_clk);
			#1 done_ack = 1'b0;
		end
	end
endmodule

// *** dv/albs_sequencer_test.sv ***
// Purpose: Self-checking bench for the adapter bring-up sequencer.
// Assumes: Timeouts shortened to 20 cycles.
// Notes: Pulse counts and cycle stamps stand in for a full trace.
`timescale 1ns/1ps
module albs_sequencer_test;
	import albs_pkg::*;
	localparam int CC = 20;
	localparam int GC = 20;
	localparam int SC = 5, IR = 4, DN = 3, CO = 2, CI = 1, SI = 0;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic init_req = 1'b0, init_discard = 1'b0, init_finished = 1'b0;
	logic rsp_en = 1'b0, ack_en = 1'b0, disc;
	logic [1:0] res = 2'h0;
	logic [7:0] dly = 8'h01;
	logic confirm_rsp, done_ack, standby, unrecognized, ready;
	logic [1:0] confirm_result;
	albs_cmd_s cmd;
	int n[6], t[6], cyc = 0, miscompares = 0, n_tests = 0, seed = 32'h0024, t0;
	always #2 core_clk = ~core_clk;
	albs_sequencer #(.CONFIRM_CYC(CC), .DISPOSAL_CYC(20), .GENERAL_CYC(GC)) albs_sequencer_i (
		.core_clk(core_clk), .sys_rst(sys_rst), .confirm_rsp(confirm_rsp),
		.confirm_result(confirm_result), .init_req(init_req), .init_discard(init_discard),
		.init_finished(init_finished), .done_ack(done_ack), .cmd(cmd), .standby(standby),
		.unrecognized(unrecognized), .ready(ready));
	albs_host_model albs_host_model_i (.core_clk(core_clk), .cmd(cmd), .rsp_en(rsp_en),
		.result(res), .ack_en(ack_en), .dly(dly), .confirm_rsp(confirm_rsp),
		.confirm_result(confirm_result), .done_ack(done_ack));
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		for (int i = 0; i < 6; i++)
			if (cmd[i] === 1'b1)
			begin
				n[i] <= n[i] + 1;
				t[i] <= cyc;
			end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// Every wait is bounded; running out counts as a miscompare and ends the run.
	task automatic wait_n(input int i, input int k, input int lim);
		int c;
		c = 0;
		while (n[i] < k && c < lim)
		begin
			@(posedge core_clk);
			#1 c++;
		end
		if (n[i] < k)
		begin
			miscompares++;
			results();
		end
	endtask
	task automatic do_reset();
		sys_rst = 1'b1;
		repeat (12) @(posedge core_clk);
		#1 check({cmd, standby, unrecognized, ready}, 0);
		sys_rst = 1'b0;
		n = '{default: 0};
		wait_n(SC, 1, 4);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(posedge core_clk);
		#1 s = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rsp_en = 1'b1;
		for (int r = 0; r < 4; r++)
		begin
			res = 2'(r);
			dly = 8'h01 + 8'($random(seed) & 7);
			do_reset();
			repeat (dly + 4) @(posedge core_clk);
			#1 check(standby, r != 3);
			check(unrecognized, r == 3);
			check({4'(n[CO]), 4'(n[CI]), 4'(n[SC])}, {4'(r >= 2), 4'(r == 3), 4'h1});
		end
		// A silent host: one resend after the timeout, then give up for good.
		rsp_en = 1'b0;
		do_reset();
		t0 = t[SC];
		wait_n(SC, 2, CC + 8);
		check(t[SC] - t0 inside {CC + 1, CC + 2}, 1);
		wait_n(CI, 1, CC + 8);
		check({unrecognized, standby, 4'(n[CO]), 4'(n[SC])}, {2'h2, 4'h1, 4'h2});
		pulse(init_req);
		repeat (6) @(posedge core_clk);
		#1 check(n[IR] + n[SI], 0);
		rsp_en = 1'b1;
		res = 2'h0;
		do_reset();
		repeat (dly + 4) @(posedge core_clk);
		for (int k = 0; k < 3; k++)
		begin
			#1 n = '{default: 0};
			disc = 1'($random(seed));
			ack_en = k > 0;
			init_discard = disc;
			pulse(init_req);
			init_discard = ~disc;
			wait_n(SI, 1, 6);
			check({4'(n[IR]), 4'(n[SI]), 4'(n[CO])}, {4'h1, 4'h1, 4'(disc)});
			check(t[SI] - t[IR], 0);
			if (disc)
				check(t[CO] < t[IR], 1);
			repeat (3) @(posedge core_clk);
			#1 pulse(init_finished);
			wait_n(DN, 1, 4);
			if (ack_en)
			begin
				repeat (dly + 4) @(posedge core_clk);
				#1 check({ready, 4'(n[DN])}, {1'b1, 4'h1});
			end
			else
			begin
				t0 = t[DN];
				wait_n(DN, 2, GC + 8);
				check(t[DN] - t0 inside {GC + 1, GC + 2}, 1);
				repeat (GC + 8) @(posedge core_clk);
				#1 check({standby, ready, 4'(n[DN])}, {2'h2, 4'h2});
			end
		end
		results();
	end
endmodule
